//--- pao_pkg.sv
// Package: constants and types for the pipelined converter output port
// Functional notes
// - Pipeline stages advance on both rising and falling sample clock edges.
// - One conversion per sample clock cycle, up to 20 MSPS.
// - Result is straight binary on ten bits, bit 9 most significant.
// - Code saturates at all ones above top, all zeros below bottom.
// - Float control high puts all ten outputs in high impedance.
// - Each sample appears on outputs after 3.5 sample clock cycles.
// - Standby high with clock stopped gives low-power state.
package pao_pkg;
  // ==========================================================
  // Widths and codes
  localparam int          RESULT_W   = 10;
  localparam int          SAMPLE_W   = 12;
  // Pipeline is counted in half cycles: 3.5 cycles = 7 edges
  localparam int          LAT_HALF   = 7;
  localparam int          STAGES     = LAT_HALF - 1;
  localparam logic [RESULT_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic [RESULT_W-1:0] CODE_MIN = 10'h000;
  localparam logic [RESULT_W-1:0] RST_CODE = 10'h000;
  localparam logic [2:0]  FILL_RST   = 3'h0;
  localparam logic [2:0]  FILL_FULL  = 3'h7;
  localparam logic [1:0]  SYNC_LOW   = 2'h0;
  localparam logic [1:0]  SYNC_HIGH  = 2'h3;
  localparam logic [3:0]  IDLE_RST   = 4'h0;
  localparam logic [3:0]  IDLE_LIMIT = 4'hF;
  localparam real         MAX_RATE_MSPS = 20.0;
  localparam int          FLOAT_DELAY_NS = 150;

  // Analog levels as unsigned samples; span bounds set the saturation points
  typedef struct packed {
    logic [SAMPLE_W-1:0] level;
    logic [SAMPLE_W-1:0] top_ref_sense;
    logic [SAMPLE_W-1:0] bottom_ref_sense;
  } pao_analog_s;

  typedef struct packed {
    logic [RESULT_W-1:0] conv_result_bits;
    logic [RESULT_W-1:0] conv_result_oe;
    logic                result_valid;
  } pao_out_s;
endpackage

//--- pao_port.sv
// Design: pipelined converter digital core with float and standby controls
`timescale 1ns/1ps
`default_nettype none
module pao_port (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             sample_clk,
  input  wire pao_pkg::pao_analog_s analog_in,
  input  wire logic             float_request,
  input  wire logic             low_power_request,
  output var  pao_pkg::pao_out_s result,
  output logic                  low_power_active
);
  import pao_pkg::*;

  // ==========================================================
  // Quantiser
  // Straight binary over the span between the two references. The divide
  // only runs for levels strictly inside the span, so the divisor is never
  // zero; a reversed reference pair simply saturates.
  function automatic logic [RESULT_W-1:0] quantise(input pao_analog_s a);
    logic [SAMPLE_W-1:0] span;
    logic [SAMPLE_W+RESULT_W-1:0] num;
    logic [SAMPLE_W+RESULT_W-1:0] q;
    span = '0;
    num  = '0;
    q    = '0;
    if (a.level >= a.top_ref_sense) begin
      quantise = CODE_MAX;
    end else if (a.level <= a.bottom_ref_sense) begin
      quantise = CODE_MIN;
    end else begin
      span = a.top_ref_sense - a.bottom_ref_sense;
      num  = {{RESULT_W{1'b0}}, SAMPLE_W'(a.level - a.bottom_ref_sense)} << RESULT_W;
      q    = num / {{RESULT_W{1'b0}}, span};
      // Midpoint maps to only the top bit set; straight binary, bit 9 MSB
      quantise = (q > {{SAMPLE_W{1'b0}}, CODE_MAX}) ? CODE_MAX : q[RESULT_W-1:0];
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  // Every pin but clock and rstn passes two flops before logic reads it. The analog word is
  // a slow level held by the source around each sample, so a plain
  // two-stage copy is used for it instead of a handshake.
  logic [1:0]  sclk_sync;
  logic [1:0]  float_sync;
  logic [1:0]  low_power_request_sync;
  logic        sclk_prev;
  pao_analog_s analog_meta;
  pao_analog_s analog_sync;

  // Sample clock and standby reset low, matching an idle, awake part
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclk_sync <= SYNC_LOW;
    end else begin
      sclk_sync <= {sclk_sync[0], sample_clk};
    end
  end

  // Float resets high so the data pins stay released until told otherwise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      float_sync <= SYNC_HIGH;
    end else begin
      float_sync <= {float_sync[0], float_request};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      low_power_request_sync <= SYNC_LOW;
    end else begin
      low_power_request_sync <= {low_power_request_sync[0], low_power_request};
    end
  end

  // References travel with the level, so each sample sees one fixed span
  always_ff @(posedge clock) begin
    if (!rstn) begin
      analog_meta <= '0;
      analog_sync <= '0;
    end else begin
      analog_meta <= analog_in;
      analog_sync <= analog_meta;
    end
  end

  // ==========================================================
  // Sample clock edges
  // Either edge advances the pipeline; each clock phase must last at
  // least one core clock or an edge is lost
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclk_prev <= 1'b0;
    end else begin
      // Resets to the idle level of the pin, so no false edge follows reset
      sclk_prev <= sclk_sync[1];
    end
  end

  logic edge_any;
  logic edge_rise;
  logic advance;
  logic take_sample;

  assign edge_any    = sclk_sync[1] ^ sclk_prev;
  assign edge_rise   = sclk_sync[1] & ~sclk_prev;
  assign advance     = edge_any & ~low_power_active;
  // Rising edges alone take new samples; falling edges only shift
  assign take_sample = advance & edge_rise;

  // ==========================================================
  // Standby
  // Entered only with the request high and no sample edge for a while,
  // since a running clock keeps the pipeline busy. Fifteen quiet clocks
  // is the limit: a sample clock slower than that is taken as stopped.
  logic [3:0] idle_cnt;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      idle_cnt <= IDLE_RST;
    end else if (edge_any || !low_power_request_sync[1]) begin
      idle_cnt <= IDLE_RST;
    end else if (idle_cnt != IDLE_LIMIT) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // Code and pipeline freeze in standby; words taken before it are kept
  // and come out first once the clock runs again
  assign low_power_active = low_power_request_sync[1] && (idle_cnt == IDLE_LIMIT);

  // ==========================================================
  // Half-cycle pipeline
  // The first stage converts on a rising edge and holds through the
  // falling one; the others move on every edge. Seven registers from
  // sampling to the output make the latency seven half cycles.
  logic [RESULT_W-1:0] stage0;
  logic [RESULT_W-1:0] pipe [STAGES];
  logic [2:0]          fill;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage0 <= RST_CODE;
    end else if (take_sample) begin
      stage0 <= quantise(analog_sync);
    end
  end

  // Reset fills the chain with the zero code; the valid flag hides it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < STAGES; i++) begin
        pipe[i] <= RST_CODE;
      end
    end else if (advance) begin
      pipe[0] <= stage0;
      for (int i = 1; i < STAGES; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // Counts edges since reset or standby; a word is trusted once the
  // pipeline has been refilled end to end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fill <= FILL_RST;
    end else if (low_power_active) begin
      fill <= FILL_RST;
    end else if (edge_any && fill != FILL_FULL) begin
      fill <= fill + 3'h1;
    end
  end

  // ==========================================================
  // Output registers
  // Code and valid move only on sample edges, so the capture side sees
  // each word stand for a whole clock phase
  logic [RESULT_W-1:0] out_code;
  logic                out_valid;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_code <= RST_CODE;
    end else if (advance) begin
      out_code <= pipe[STAGES-1];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_valid <= 1'b0;
    end else if (advance) begin
      out_valid <= (fill == FILL_FULL);
    end
  end

  // ==========================================================
  // Pin drive
  // Float control releases all ten data pins regardless of code. The
  // code register keeps running, so data is current when driven again;
  // while floated, valid reads low even with a full pipeline.
  logic drive_on;

  assign drive_on = ~float_sync[1];

  always_comb begin
    result.conv_result_bits = out_code;
    result.conv_result_oe   = drive_on ? {RESULT_W{1'b1}} : '0;
    result.result_valid     = out_valid && drive_on;
  end
endmodule
`default_nettype wire

//--- pao_cap.sv
// Model of the capture logic that clocks the converter
`timescale 1ns/1ps
`default_nettype none
module pao_cap (
  input  wire logic clock,
  input  wire logic run,
  output logic      sample_clk = 1'h0);
  logic [1:0] n = 2'h0; // Three-clock phases keep the duty cycle at half
  // Clock stands still while stopped, as standby needs
  always @(posedge clock) begin
    n <= (!run || n == 2'h2) ? 2'h0 : n + 2'h1;
    if (run && n == 2'h2) sample_clk <= !sample_clk;
  end
endmodule
`default_nettype wire

//--- pao_port_sva.sv
// Checker for the converter output port
`timescale 1ns/1ps
`default_nettype none
module pao_sva (
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              sample_clk,
  input wire logic              float_request,
  input wire logic              low_power_request,
  input wire pao_pkg::pao_out_s result,
  input wire logic              low_power_active);
  import pao_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence idle; low_power_request && $stable(sample_clk); endsequence
  chk_oe_off: assert property (float_request[*3] |->
    result.conv_result_oe == 10'h000) else $error("outputs driven while floated");
  chk_code_hold: assert property ($stable(sample_clk)[*8] |=>
    $stable(result.conv_result_bits)) else $error("code moved without clock");
  chk_lp_entry: assert property (idle[*8] ##1 idle[*8] ##1 idle[*8] |->
    low_power_active) else $error("standby not entered");
  chk_oe_on: assert property ((!float_request)[*3] |->
    result.conv_result_oe == 10'h3FF) else $error("outputs floated while enabled");
  chk_lp_exit: assert property ((!low_power_request)[*3] |->
    !low_power_active) else $error("standby held without request");
  chk_lp_freeze: assert property (low_power_active |=>
    $stable(result.conv_result_bits)) else $error("code moved in standby");
  cov_standby: cover property (low_power_active);
  cov_float: cover property (result.conv_result_oe == 10'h000);
  cov_mid: cover property (result.conv_result_bits == 10'h200);
endmodule
bind pao_port pao_sva sva (.*);
`default_nettype wire

//--- testbench.sv
// Bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pao_pkg::*;
  logic clock = 1'h0, rstn = 1'h0, run = 1'h0, float_request = 1'h1, low_power_request = 1'h0;
  logic sample_clk, low_power_active;
  pao_analog_s analog_in = {12'h000, 12'hC00, 12'h400};
  pao_out_s result;
  int failures = 0, n_tests = 0;
  initial forever #25 clock = !clock;
  pao_cap cap (
    .clock      (clock),
    .run        (run),
    .sample_clk (sample_clk)
  );
  pao_port dut (
    .clock             (clock),
    .rstn              (rstn),
    .sample_clk        (sample_clk),
    .analog_in         (analog_in),
    .float_request     (float_request),
    .low_power_request (low_power_request),
    .result            (result),
    .low_power_active  (low_power_active)
  );
  task automatic cmp(input logic [9:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // References at C00 and 400: the exact boundaries are the awkward cases
  task automatic t_codes;
    logic [21:0] tab [3] = '{{12'hC00, CODE_MAX}, {12'h800, 10'h200}, {12'h400, CODE_MIN}};
    foreach (tab[i]) begin
      @(posedge clock);
      analog_in.level <= tab[i][21:10];
      repeat (60) @(posedge clock);
      #1;
      cmp(result.conv_result_bits, tab[i][9:0]);
      cmp({9'h000, result.result_valid}, 10'h001);
    end
    $display("code test done");
  endtask
  // Pin edge to sample: 3 clocks; then 7 half cycles of 3 clocks each
  task automatic t_latency;
    @(posedge sample_clk);
    analog_in.level <= 12'h800;
    repeat (LAT_HALF * 3 + 2) @(posedge clock);
    #1;
    cmp(result.conv_result_bits, CODE_MIN);
    @(posedge clock);
    #1;
    cmp(result.conv_result_bits, 10'h200);
    $display("latency test done");
  endtask
  task automatic t_quiet;
    @(posedge clock);
    {run, float_request, low_power_request} <= 3'h3;
    repeat (30) @(posedge clock);
    #1;
    cmp(result.conv_result_oe, 10'h000);
    cmp({9'h000, result.result_valid}, 10'h000);
    cmp({9'h000, low_power_active}, 10'h001);
    @(posedge clock);
    {run, float_request, low_power_request} <= 3'h4;
    repeat (4) @(posedge clock);
    #1;
    cmp(result.conv_result_oe, 10'h3FF);
    cmp({9'h000, low_power_active}, 10'h000);
    $display("float and standby test done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    {rstn, float_request, run} <= 3'h5;
    t_codes();
    t_latency();
    t_quiet();
    t_codes();
    close_out();
  end
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
